// ===== ecl_top.sv
// Logging, capture, port and FIFO control with an APB register slave.
//
// Register access over APB and the register offsets were decided locally.
`include "ecl_regs.svh"

module ecl_top #(
  parameter int REC_DEPTH = `ECL_REC_DEPTH,
  parameter int LEN_W = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // APB slave.
  input wire ecl_pkg::ecl_apb_t apb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder channel side.
  input wire logic [2:0][31:0] enc_count,
  input wire logic [2:0] enc_trig,
  // Digital port pins.
  input wire logic [3:0] din_pin,
  output logic [3:0] dout_pin
);

  localparam int PW = $clog2(REC_DEPTH);
  localparam int CW = $clog2(REC_DEPTH + 1);

  if (REC_DEPTH < 2 || LEN_W < 1 || LEN_W > 16)
  begin : g_chk
    $error("ecl_top parameters out of range");
  end

  // ----------------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------------
  logic setup;
  logic done;
  logic wr;
  logic rd_done;
  logic all1;
  logic [7:0] a;
  logic [31:0] cmd;
  logic [31:0] rdata;
  logic hit;

  assign a = apb.paddr;
  assign setup = apb.psel & ~apb.penable;
  assign done = apb.psel & apb.penable & pready;
  assign wr = done & apb.pwrite;
  assign rd_done = done & ~apb.pwrite;
  assign all1 = apb.pwdata == `ECL_ALL_ONES;
  assign cmd = (wr && a == `ECL_OFF_CMD) ? apb.pwdata : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Software settings
  // ----------------------------------------------------------------------
  logic [31:0] mult;
  logic [31:0] samples;
  logic [7:0] log_cfg;
  logic [3:0] out_port;
  logic out_sel;
  logic [LEN_W-1:0] stretch_len;
  logic [7:0] din_cfg;
  logic [2:0] cap_en;
  logic fifo_en;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      mult <= `ECL_RST_MULT;
      samples <= 32'h0000_0000;
      log_cfg <= 8'h00;
      out_port <= 4'h0;
      out_sel <= 1'b0;
      stretch_len <= LEN_W'(`ECL_RST_STRETCH);
      din_cfg <= 8'h00;
      cap_en <= 3'h0;
      fifo_en <= 1'b0;
    end
    else if (wr)
    begin
      case (a)
        `ECL_OFF_MULT: mult <= apb.pwdata;
        `ECL_OFF_SAMPLES: samples <= apb.pwdata;
        `ECL_OFF_LOG_CFG: log_cfg <= apb.pwdata[7:0];
        `ECL_OFF_OUT_PORT: out_port <= apb.pwdata[3:0];
        `ECL_OFF_OUT_CFG:
        begin
          out_sel <= apb.pwdata[`ECL_OUT_CFG_SEL];
          stretch_len <= apb.pwdata[`ECL_OUT_CFG_LEN_LSB +: LEN_W];
        end
        `ECL_OFF_DIN_CFG: din_cfg <= apb.pwdata[7:0];
        `ECL_OFF_CAP_EN: cap_en <= apb.pwdata[2:0];
        `ECL_OFF_FIFO_CTRL: fifo_en <= apb.pwdata[0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Sampling rate counter and time tag
  // ----------------------------------------------------------------------
  logic [31:0] rate_cnt;
  logic [31:0] mult_m1;
  logic tick;
  logic [31:0] time_tag;

  assign mult_m1 = (mult == 32'h0000_0000) ? 32'h0000_0000 : mult - 32'd1;
  assign tick = rate_cnt == 32'h0000_0000;

  // A period lasts mult cycles; zero is served as one.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      rate_cnt <= 32'h0000_0000;
    else if (tick)
      rate_cnt <= mult_m1;
    else
      rate_cnt <= rate_cnt - 32'd1;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || cmd[`ECL_CMD_TIME_RST])
      time_tag <= 32'h0000_0000;
    else
      time_tag <= time_tag + 32'd1;
  end

  // ----------------------------------------------------------------------
  // Digital inputs and edge triggers
  // ----------------------------------------------------------------------
  logic [3:0] din_s;
  logic [3:0] din_prev;
  logic [3:0] din_edge;
  logic [3:0] din_new;
  logic [3:0] din_flag;
  logic din_clr;

  ecl_sync #(.W(4)) u_sync (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .d(din_pin),
    .q(din_s)
  );

  assign din_edge = (din_cfg[7:4] & din_s & ~din_prev)
    | (~din_cfg[7:4] & ~din_s & din_prev);
  // A flag that is being cleared in this cycle no longer blocks a new edge.
  assign din_new = din_cfg[3:0] & din_edge
    & ~(din_flag & ~{4{din_clr | fifo_en}});
  assign din_clr = wr && a == `ECL_OFF_DIN_STAT && all1;

  // A new edge wins over a clear in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      din_prev <= 4'h0;
      din_flag <= 4'h0;
    end
    else
    begin
      din_prev <= din_s;
      din_flag <= din_new | (din_flag & ~{4{din_clr | fifo_en}});
    end
  end

  // ----------------------------------------------------------------------
  // Acquisition control
  // ----------------------------------------------------------------------
  ecl_pkg::ecl_acq_t state;
  logic [31:0] remain;
  logic cond;
  logic store;
  logic start;
  logic stop;

  assign start = cmd[`ECL_CMD_START];
  assign stop = cmd[`ECL_CMD_STOP];
  assign cond = ((din_s ^ log_cfg[7:4]) & log_cfg[3:0]) == 4'h0;
  assign store = tick && cond && state != ecl_pkg::ACQ_IDLE;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      state <= ecl_pkg::ACQ_IDLE;
      remain <= 32'h0000_0000;
    end
    else if (stop)
      state <= ecl_pkg::ACQ_IDLE;
    else if (start)
    begin
      remain <= samples;
      if (samples == 32'h0000_0000)
        state <= ecl_pkg::ACQ_IDLE;
      else
        state <= ecl_pkg::ACQ_ARM;
    end
    else
    begin
      case (state)
        ecl_pkg::ACQ_ARM, ecl_pkg::ACQ_RUN:
        begin
          if (store)
          begin
            remain <= remain - 32'd1;
            if (remain == 32'd1)
              state <= ecl_pkg::ACQ_IDLE;
            else
              state <= ecl_pkg::ACQ_RUN;
          end
        end
        ecl_pkg::ACQ_IDLE: ;
        default: state <= ecl_pkg::ACQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Capture of time tag and channel counts
  // ----------------------------------------------------------------------
  logic cap_evt;
  logic [31:0] time_latch;
  logic [2:0][31:0] ch_latch;
  logic [2:0] ch_flag;
  logic [2:0] ch_clr;

  assign cap_evt = cmd[`ECL_CMD_CAPTURE] | (|enc_trig) | (|din_new) | store;
  assign ch_clr[0] = wr && a == `ECL_OFF_CH0_STAT && all1;
  assign ch_clr[1] = wr && a == `ECL_OFF_CH1_STAT && all1;
  assign ch_clr[2] = wr && a == `ECL_OFF_CH2_STAT && all1;

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      time_latch <= 32'h0000_0000;
      ch_latch <= '0;
    end
    else if (cap_evt)
    begin
      time_latch <= time_tag;
      for (int i = 0; i < 3; i++)
      begin
        if (cap_en[i])
          ch_latch[i] <= enc_count[i];
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      ch_flag <= 3'h0;
    else
      ch_flag <= ({3{cap_evt}} & cap_en)
        | (ch_flag & ~(ch_clr | {3{fifo_en}}));
  end

  // ----------------------------------------------------------------------
  // Record FIFO
  // ----------------------------------------------------------------------
  ecl_pkg::ecl_rec_t mem [REC_DEPTH];
  ecl_pkg::ecl_rec_t rec_in;
  ecl_pkg::ecl_rec_t head;
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] rec_cnt;
  logic [2:0] widx;
  logic push;
  logic pop;
  logic word_rd;
  logic flush;
  logic [31:0] fifo_word;

  always_comb
  begin
    rec_in.stamp = time_tag;
    rec_in.info = {24'h00_0000, 1'b0, cap_en, din_new};
    for (int i = 0; i < 3; i++)
      rec_in.cnt[i] = cap_en[i] ? enc_count[i] : ch_latch[i];
  end

  assign flush = cmd[`ECL_CMD_FLUSH];
  assign push = cap_evt && fifo_en && rec_cnt != CW'(REC_DEPTH);
  assign word_rd = rd_done && a == `ECL_OFF_FIFO_DATA && rec_cnt != '0;
  assign pop = word_rd && widx == 3'd4;
  assign head = mem[rd_ptr];

  always_comb
  begin
    case (widx)
      3'd0: fifo_word = head.stamp;
      3'd1: fifo_word = head.cnt[0];
      3'd2: fifo_word = head.cnt[1];
      3'd3: fifo_word = head.cnt[2];
      default: fifo_word = head.info;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wr_ptr] <= rec_in;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n || flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      rec_cnt <= '0;
      widx <= 3'd0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PW'(REC_DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == PW'(REC_DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      if (push && !pop)
        rec_cnt <= rec_cnt + CW'(1);
      else if (pop && !push)
        rec_cnt <= rec_cnt - CW'(1);
      if (word_rd)
        widx <= (widx == 3'd4) ? 3'd0 : widx + 3'd1;
    end
  end

  // ----------------------------------------------------------------------
  // Read multiplexer and bus answer
  // ----------------------------------------------------------------------
  always_comb
  begin
    rdata = 32'h0000_0000;
    hit = 1'b1;
    case (a)
      `ECL_OFF_MULT: rdata = mult;
      `ECL_OFF_SAMPLES: rdata = samples;
      `ECL_OFF_LOG_CFG: rdata = {24'h00_0000, log_cfg};
      `ECL_OFF_CMD: rdata = 32'h0000_0000;
      `ECL_OFF_REMAIN: rdata = remain;
      `ECL_OFF_RATE_CNT: rdata = rate_cnt;
      `ECL_OFF_IN_PORT: rdata = {28'h000_0000, din_s};
      `ECL_OFF_OUT_PORT: rdata = {28'h000_0000, out_port};
      `ECL_OFF_OUT_CFG:
      begin
        rdata[`ECL_OUT_CFG_SEL] = out_sel;
        rdata[`ECL_OUT_CFG_LEN_LSB +: LEN_W] = stretch_len;
      end
      `ECL_OFF_DIN_CFG: rdata = {24'h00_0000, din_cfg};
      `ECL_OFF_DIN_STAT: rdata = {28'h000_0000, din_flag};
      `ECL_OFF_CH0_STAT: rdata = {31'h0000_0000, ch_flag[0]};
      `ECL_OFF_CH1_STAT: rdata = {31'h0000_0000, ch_flag[1]};
      `ECL_OFF_CH2_STAT: rdata = {31'h0000_0000, ch_flag[2]};
      `ECL_OFF_CAP_EN: rdata = {29'h0000_0000, cap_en};
      `ECL_OFF_CH0_LATCH: rdata = ch_latch[0];
      `ECL_OFF_CH1_LATCH: rdata = ch_latch[1];
      `ECL_OFF_CH2_LATCH: rdata = ch_latch[2];
      `ECL_OFF_TIME_LATCH: rdata = time_latch;
      `ECL_OFF_FIFO_CTRL: rdata = {31'h0000_0000, fifo_en};
      `ECL_OFF_FIFO_COUNT: rdata = 32'(rec_cnt);
      `ECL_OFF_FIFO_DATA:
        rdata = (rec_cnt != '0) ? fifo_word : 32'h0000_0000;
      `ECL_OFF_ACQ_STAT: rdata = {30'h0000_0000, state};
      default: hit = 1'b0;
    endcase
  end

  // Answer is prepared in the setup cycle, so pready rises in the first
  // access cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~hit;
      prdata <= setup ? rdata : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Output port pins
  // ----------------------------------------------------------------------
  logic [3:0] trig_src;
  logic [3:0] stretched;

  assign trig_src = {|din_new, enc_trig};

  for (genvar g = 0; g < 4; g++)
  begin : g_str
    ecl_stretch #(.W(LEN_W)) u_str (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .trig(trig_src[g]),
      .len(stretch_len),
      .pulse(stretched[g])
    );
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
      dout_pin <= 4'h0;
    else
      dout_pin <= out_sel ? stretched : out_port;
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_TICK_RELOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    tick |=> rate_cnt == $past(mult_m1))
    else $error("rate counter did not reload");

  AST_STORE_BOUNDARY: assert property (@(posedge sys_clk)
    disable iff (!reset_n)
    state == ecl_pkg::ACQ_RUN && !start && !stop
      |=> remain == $past(remain) || $past(tick))
    else $error("sample stored off a period boundary");

  AST_START_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    start && !stop |=> remain == $past(samples))
    else $error("remaining count not loaded at start");

  AST_REMAIN_DEC: assert property (@(posedge sys_clk) disable iff (!reset_n)
    store && !start && !stop |=> remain == $past(remain) - 32'd1)
    else $error("remaining count not decremented");

  AST_AUTO_END: assert property (@(posedge sys_clk) disable iff (!reset_n)
    store && remain == 32'd1 && !start && !stop
      |=> state == ecl_pkg::ACQ_IDLE)
    else $error("acquisition did not end at count");

  AST_STOP: assert property (@(posedge sys_clk) disable iff (!reset_n)
    stop |=> state == ecl_pkg::ACQ_IDLE)
    else $error("stop did not abort acquisition");

  AST_WAIT_COND: assert property (@(posedge sys_clk) disable iff (!reset_n)
    state == ecl_pkg::ACQ_ARM && !cond |=> state != ecl_pkg::ACQ_RUN)
    else $error("acquisition began without condition");

  AST_TIME_LATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cap_evt |=> time_latch == $past(time_tag))
    else $error("time tag not latched on trigger");

  AST_CH_LATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    cap_evt && cap_en[0] |=> ch_latch[0] == $past(enc_count[0]))
    else $error("channel count not latched");

  AST_DIN_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
    din_clr |=> din_flag == $past(din_new))
    else $error("input flags not cleared");

  AST_FLUSH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    flush |=> rec_cnt == '0)
    else $error("flush left records");

  AST_FIFO_OFF: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !fifo_en && cap_evt |=> rec_cnt <= $past(rec_cnt))
    else $error("record stored while FIFO disabled");

endmodule

// ===== ecl_regs.svh
// Register offsets, field positions and reset values of the logging block.
//
// What this block does
// - A 32-bit writable multiplier sets the sampling period length.
// - Logged samples are taken only on sampling period boundaries.
// - An acquisition waits until the configured input condition holds.
// - While running, each period stores the sample if the condition holds.
// - A writable sample count sets how many samples a start collects.
// - The run ends by itself when the stored samples reach the count.
// - A stop command aborts a running acquisition at once.
// - Software can read the samples still to be collected.
// - A read-only input port register shows the digital input pins.
// - A writable output port register reads back its last value.
// - A setting selects output register or trigger pulses for pins.
// - Trigger pulses on output pins are stretched to a set length.
// - Software can read the running sampling rate counter any time.
// - Capture latches time tag and enabled channel counts together.
// - Writing all ones to a channel status register clears its flags.
// - Writing all ones to input status register clears all input flags.
// - A flush command empties the FIFO and zeroes its record count.
// - FIFO disable stops storage and automatic clearing of flags.
// - FIFO enable starts storage and automatic clearing of flags.
// - The FIFO holds up to 204 records of 5 words each.
// - Every trigger latches the time tag, with or without channels.
`ifndef ECL_REGS_SVH
`define ECL_REGS_SVH

`define ECL_OFF_MULT 8'h00
`define ECL_OFF_SAMPLES 8'h04
`define ECL_OFF_LOG_CFG 8'h08
`define ECL_OFF_CMD 8'h0C
`define ECL_OFF_REMAIN 8'h10
`define ECL_OFF_RATE_CNT 8'h14
`define ECL_OFF_IN_PORT 8'h18
`define ECL_OFF_OUT_PORT 8'h1C
`define ECL_OFF_OUT_CFG 8'h20
`define ECL_OFF_DIN_CFG 8'h24
`define ECL_OFF_DIN_STAT 8'h28
`define ECL_OFF_CH0_STAT 8'h2C
`define ECL_OFF_CH1_STAT 8'h30
`define ECL_OFF_CH2_STAT 8'h34
`define ECL_OFF_CAP_EN 8'h38
`define ECL_OFF_CH0_LATCH 8'h3C
`define ECL_OFF_CH1_LATCH 8'h40
`define ECL_OFF_CH2_LATCH 8'h44
`define ECL_OFF_TIME_LATCH 8'h48
`define ECL_OFF_FIFO_CTRL 8'h4C
`define ECL_OFF_FIFO_COUNT 8'h50
`define ECL_OFF_FIFO_DATA 8'h54
`define ECL_OFF_ACQ_STAT 8'h58

`define ECL_CMD_START 0
`define ECL_CMD_STOP 1
`define ECL_CMD_CAPTURE 2
`define ECL_CMD_FLUSH 3
`define ECL_CMD_TIME_RST 4

`define ECL_OUT_CFG_SEL 0
`define ECL_OUT_CFG_LEN_LSB 16

`define ECL_RST_MULT 32'h0000_0001
`define ECL_RST_STRETCH 16'h0001
`define ECL_ALL_ONES 32'hFFFF_FFFF
`define ECL_REC_DEPTH 204

`endif

// ===== ecl_pkg.sv
// Types shared by the logging block modules.
package ecl_pkg;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } ecl_apb_t;

  typedef struct packed {
    logic [31:0] info;
    logic [2:0][31:0] cnt;
    logic [31:0] stamp;
  } ecl_rec_t;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b00,
    ACQ_ARM = 2'b01,
    ACQ_RUN = 2'b11
  } ecl_acq_t;

endpackage

// ===== ecl_sync.sv
// Two flip-flop synchroniser for pin inputs.
module ecl_sync #(
  parameter int W = 4
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Data.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  if (W < 1)
  begin : g_chk
    $error("ecl_sync width must be at least one");
  end

  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ===== ecl_stretch.sv
// Pulse stretcher for one trigger-out pin.
module ecl_stretch #(
  parameter int W = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic reset_n,
  // Pulse in, length and stretched pulse out.
  input wire logic trig,
  input wire logic [W-1:0] len,
  output logic pulse
);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;

  if (W < 1)
  begin : g_chk
    $error("ecl_stretch width must be at least one");
  end

  always_comb
  begin
    if (trig)
      next_cnt = len;
    else if (cnt != '0)
      next_cnt = cnt - W'(1);
    else
      next_cnt = '0;
  end

  // The pulse lasts len cycles after the trigger cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!reset_n)
    begin
      cnt <= '0;
      pulse <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      pulse <= next_cnt != '0;
    end
  end

  AST_STRETCH_LEN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    trig && len != '0 |=> pulse)
    else $error("stretched pulse did not start");

endmodule

// ===== ecl_host.sv
// APB host model that issues register transfers to the logging block.
module ecl_host (
  // Clock.
  input wire logic sys_clk,
  // APB master side.
  output ecl_pkg::ecl_apb_t apb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  timeunit 1ns;
  timeprecision 1ns;

  initial apb = '0;

  // Request is held until pready is seen, then released at that edge.
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    @(posedge sys_clk);
    apb <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge sys_clk);
    apb.penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    apb <= '0;
  endtask
endmodule

// ===== ecl_top_tb.sv
// Self-checking testbench of the logging and capture block.
`include "ecl_regs.svh"

module ecl_top_tb;
  timeunit 1ns;
  timeprecision 1ns;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  ecl_pkg::ecl_apb_t apb;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready;
  logic pslverr;
  logic err;
  logic [2:0][31:0] enc_count = '0;
  logic [2:0] enc_trig = 3'h0;
  logic [3:0] din_pin = 4'h0;
  logic [3:0] dout_pin;
  int num_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  ecl_top #(.REC_DEPTH(4), .LEN_W(16)) u_dut (.sys_clk(sys_clk),
    .reset_n(reset_n), .apb(apb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .enc_count(enc_count), .enc_trig(enc_trig),
    .din_pin(din_pin), .dout_pin(dout_pin));

  ecl_host u_host (.sys_clk(sys_clk), .apb(apb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // ----------------------------------------
  // Clock, timeout and shared tasks.
  // ----------------------------------------
  initial forever #20 sys_clk = ~sys_clk;

  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    u_host.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    u_host.xfer(1'b0, a, 32'h0000_0000, rdat, err);
  endtask

  // Polls the run state until the acquisition is idle again.
  task automatic wait_idle;
    repeat (40)
    begin
      rd(`ECL_OFF_ACQ_STAT);
      if (rdat === 32'h0000_0000)
        break;
    end
  endtask

  // ----------------------------------------
  // Scenarios.
  // ----------------------------------------
  task automatic t_regs;
    rd(`ECL_OFF_MULT);
    chk(rdat, `ECL_RST_MULT);
    wr(`ECL_OFF_MULT, 32'hDEAD_BEEF);
    rd(`ECL_OFF_MULT);
    chk(rdat, 32'hDEAD_BEEF);
    // A long period reloads only at expiry, so a reset restores a short one.
    reset_n <= 1'b0;
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    rd(`ECL_OFF_MULT);
    chk(rdat, `ECL_RST_MULT);
    wr(`ECL_OFF_OUT_PORT, 32'h0000_000A);
    rd(`ECL_OFF_OUT_PORT);
    chk(rdat, 32'h0000_000A);
    chk(32'(dout_pin), 32'h0000_000A);
    @(posedge sys_clk);
    din_pin <= 4'h6;
    repeat (3) @(posedge sys_clk);
    rd(`ECL_OFF_IN_PORT);
    chk(rdat, 32'h0000_0006);
    din_pin <= 4'h0;
    rd(8'hFC);
    chk(32'(err), 32'h0000_0001);
    wr(`ECL_OFF_MULT, 32'h0000_0032);
    rd(`ECL_OFF_RATE_CNT);
    chk(32'(rdat < 32'h0000_0032), 32'h0000_0001);
  endtask

  task automatic t_log;
    wr(`ECL_OFF_LOG_CFG, 32'h0000_0000);
    wr(`ECL_OFF_MULT, 32'h0000_0004);
    wr(`ECL_OFF_SAMPLES, 32'h0000_0003);
    wr(`ECL_OFF_CMD, 32'h0000_0001);
    wait_idle();
    chk(rdat, 32'h0000_0000);
    rd(`ECL_OFF_REMAIN);
    chk(rdat, 32'h0000_0000);
    wr(`ECL_OFF_MULT, 32'h0000_0064);
    wr(`ECL_OFF_SAMPLES, 32'h0000_0064);
    wr(`ECL_OFF_CMD, 32'h0000_0001);
    wr(`ECL_OFF_CMD, 32'h0000_0002);
    rd(`ECL_OFF_ACQ_STAT);
    chk(rdat, 32'h0000_0000);
    rd(`ECL_OFF_REMAIN);
    chk(rdat, 32'h0000_0064);
  endtask

  task automatic t_arm;
    wr(`ECL_OFF_MULT, 32'h0000_0004);
    wr(`ECL_OFF_LOG_CFG, 32'h0000_0011);
    wr(`ECL_OFF_SAMPLES, 32'h0000_0002);
    wr(`ECL_OFF_CMD, 32'h0000_0001);
    repeat (20) @(posedge sys_clk);
    rd(`ECL_OFF_ACQ_STAT);
    chk(rdat, 32'h0000_0001);
    rd(`ECL_OFF_REMAIN);
    chk(rdat, 32'h0000_0002);
    din_pin <= 4'h1;
    wait_idle();
    chk(rdat, 32'h0000_0000);
    din_pin <= 4'h0;
    wr(`ECL_OFF_LOG_CFG, 32'h0000_0000);
  endtask

  task automatic t_cap;
    enc_count <= {32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
    wr(`ECL_OFF_CAP_EN, 32'h0000_0005);
    wr(`ECL_OFF_CMD, 32'h0000_0004);
    rd(`ECL_OFF_CH0_LATCH);
    chk(rdat, 32'h1111_1111);
    rd(`ECL_OFF_CH1_LATCH);
    chk(rdat, 32'h0000_0000);
    rd(`ECL_OFF_CH2_LATCH);
    chk(rdat, 32'h3333_3333);
    rd(`ECL_OFF_CH0_STAT);
    chk(rdat, 32'h0000_0001);
    wr(`ECL_OFF_CH0_STAT, `ECL_ALL_ONES);
    rd(`ECL_OFF_CH0_STAT);
    chk(rdat, 32'h0000_0000);
    wr(`ECL_OFF_DIN_CFG, 32'h0000_0011);
    din_pin <= 4'h1;
    repeat (4) @(posedge sys_clk);
    rd(`ECL_OFF_DIN_STAT);
    chk(rdat, 32'h0000_0001);
    wr(`ECL_OFF_DIN_STAT, `ECL_ALL_ONES);
    rd(`ECL_OFF_DIN_STAT);
    chk(rdat, 32'h0000_0000);
    wr(`ECL_OFF_FIFO_CTRL, 32'h0000_0001);
    wr(`ECL_OFF_CMD, 32'h0000_0004);
    rd(`ECL_OFF_FIFO_COUNT);
    chk(rdat, 32'h0000_0001);
    rd(`ECL_OFF_FIFO_DATA);
    rd(`ECL_OFF_FIFO_DATA);
    chk(rdat, 32'h1111_1111);
    rd(`ECL_OFF_CH0_STAT);
    chk(rdat, 32'h0000_0000);
    wr(`ECL_OFF_CMD, 32'h0000_0004);
    wr(`ECL_OFF_CMD, 32'h0000_0008);
    rd(`ECL_OFF_FIFO_COUNT);
    chk(rdat, 32'h0000_0000);
    wr(`ECL_OFF_FIFO_CTRL, 32'h0000_0000);
    wr(`ECL_OFF_CMD, 32'h0000_0004);
    rd(`ECL_OFF_CH0_STAT);
    chk(rdat, 32'h0000_0001);
    rd(`ECL_OFF_FIFO_COUNT);
    chk(rdat, 32'h0000_0000);
  endtask

  task automatic t_out;
    int n;
    n = 0;
    wr(`ECL_OFF_OUT_CFG, 32'h0003_0001);
    @(posedge sys_clk);
    enc_trig <= 3'h2;
    @(posedge sys_clk);
    enc_trig <= 3'h0;
    repeat (10)
    begin
      @(negedge sys_clk);
      n += dout_pin[1];
    end
    chk(32'(n), 32'h0000_0003);
  endtask

  // ----------------------------------------
  // Main sequence.
  // ----------------------------------------
  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_regs();
    t_log();
    t_arm();
    t_cap();
    t_out();
    report_and_stop();
  end
endmodule
